// >>> src/codec_ctrl_params.svh
// Register map, reset values and word-length code of the codec control bank
`ifndef CODEC_CTRL_PARAMS_SVH
`define CODEC_CTRL_PARAMS_SVH

`define ADDR_W 12
`define OFF_AIC 12'h100
`define OFF_CR1 12'h104
`define OFF_CR2 12'h108
`define OFF_CLK 12'h10c
`define OFF_RATE 12'h110
`define OFF_PM1 12'h114
`define OFF_PM2 12'h118

`define RST_AIC 8'h0c
`define RST_CR1 8'haa
`define RST_CR2 8'h78
`define RST_CLK 4'h0
`define RST_RATE 8'h00
`define RST_PM1 8'hff
`define RST_PM2 6'h03

`define RDATA_ZERO 32'h0000_0000
`define WL_16 2'h0

`endif

// >>> src/codec_ctrl_pkg.sv
// Types shared by the codec control bank
package codec_ctrl_pkg;

	typedef enum logic [1:0] {
		gain_independent = 2'h0,
		gain_use_right = 2'h1,
		gain_use_left = 2'h2,
		gain_use_left_b = 2'h3
	} gain_couple_type;

	typedef enum logic [1:0] {
		word_16 = 2'h0,
		word_18 = 2'h1,
		word_20 = 2'h2,
		word_24 = 2'h3
	} word_length_type;

endpackage : codec_ctrl_pkg

// >>> src/voice_codec_control_regs.sv
// Control register bank of the voice-band audio codec
//
// Decided for this implementation: strobed register access.
`include "codec_ctrl_params.svh"

// Functional notes
// - Interface bits 3,2 choose serial; reset 1; software keeps them at 1.
// - Interface bits 1,0 choose DSP or I2S for DAC and ADC; reset 0.
// - Control one bit 7 powers down microphone bias buffer; reset 1.
// - Control one bit 6 selects stereo or mono DAC path; reset stereo.
// - Control one bit 5 soft-mutes the DAC; reset muted.
// - Control one bit 4 disables headphone signal; reset 0.
// - Control one bits 3,2 add DAC and bypass to mixer; reset 1,0.
// - Control one bit 1 mutes bridge-tied-load stage; reset 1.
// - Control two bit 7 enables DAC de-emphasis; reset off.
// - Word-length fields 6:5 and 4:3 reset to 11; only 00 works.
// - Control two bit 2 enables ADC high-pass filter; reset off.
// - Control two bit 1 selects microphone pair one or two; reset one.
// - Master clock field 3:0; 0000 is 12 MHz and the reset value.
// - DAC rate field 7:4 selects 96k down to 8k; reset 0000.
// - ADC rate field 3:0 uses the same mapping; reset 0000.
// - Power one bits 7..1 power down sections when set; reset 1.
// - Power two bits 5,4 couple the DAC mixing channel gains.
// - Power two bit 3 sets mic amp gain 0 or 20 dB; reset 0 dB.
// - Power two bit 2 powers down common-mode buffer; reset 0.
// - Power two bits 1,0 select full power-down and sleep; reset 1.
module voice_codec_control_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Audio interface format
	output logic dac_serial,
	output logic adc_serial,
	output logic dac_i2s,
	output logic adc_i2s,
	// Mute and mixer routing
	output logic mic_bias_powerdown,
	output logic dac_mono,
	output logic dac_soft_mute,
	output logic headphone_disable,
	output logic mixer_dac_input,
	output logic mixer_bypass_input,
	output logic bridge_stage_mute,
	// Filters, sources and word length
	output logic deemphasis_enable,
	output codec_ctrl_pkg::word_length_type dac_word_length,
	output codec_ctrl_pkg::word_length_type adc_word_length,
	output logic word_length_unsupported,
	output logic adc_highpass_enable,
	output logic microphone_select,
	// Clocking
	output logic [3:0] master_clock_select,
	output logic master_clock_unsupported,
	output logic [3:0] dac_rate_select,
	output logic [3:0] adc_rate_select,
	// Power control
	output logic dac_powerdown,
	output logic output_stage_powerdown,
	output logic mixer_powerdown,
	output logic adc_powerdown,
	output logic line_input_powerdown,
	output logic bridge_conditioning_powerdown,
	output logic line_out_powerdown,
	output codec_ctrl_pkg::gain_couple_type mix_gain_couple,
	output logic mic_amp_gain,
	output logic common_mode_buffer_powerdown,
	output logic full_powerdown,
	output logic sleep_select
);

	// Storage, low bits of each register only
	logic [7:0] aic_q;
	logic [7:0] cr1_q;
	logic [7:0] cr2_q;
	logic [3:0] clk_q;
	logic [7:0] rate_q;
	logic [7:0] pm1_q;
	logic [5:0] pm2_q;
	logic [31:0] rdata_d;

	// Reset images; storage and outputs share one source so they cannot drift
	localparam logic [7:0] aic_rst = `RST_AIC;
	localparam logic [7:0] cr1_rst = `RST_CR1;
	localparam logic [7:0] cr2_rst = `RST_CR2;
	localparam logic [3:0] clk_rst = `RST_CLK;
	localparam logic [7:0] rate_rst = `RST_RATE;
	localparam logic [7:0] pm1_rst = `RST_PM1;
	localparam logic [5:0] pm2_rst = `RST_PM2;

	// Address decoded once; write and read paths share it
	logic hit_aic;
	logic hit_cr1;
	logic hit_cr2;
	logic hit_clk;
	logic hit_rate;
	logic hit_pm1;
	logic hit_pm2;
	logic hit_none;
	logic wr_aic;
	logic wr_cr1;
	logic wr_cr2;
	logic wr_clk;
	logic wr_rate;
	logic wr_pm1;
	logic wr_pm2;

	always_comb
	begin
		hit_aic = 1'b0;
		hit_cr1 = 1'b0;
		hit_cr2 = 1'b0;
		hit_clk = 1'b0;
		hit_rate = 1'b0;
		hit_pm1 = 1'b0;
		hit_pm2 = 1'b0;
		hit_none = 1'b0;
		if (reg_addr == `OFF_AIC)
			hit_aic = 1'b1;
		else if (reg_addr == `OFF_CR1)
			hit_cr1 = 1'b1;
		else if (reg_addr == `OFF_CR2)
			hit_cr2 = 1'b1;
		else if (reg_addr == `OFF_CLK)
			hit_clk = 1'b1;
		else if (reg_addr == `OFF_RATE)
			hit_rate = 1'b1;
		else if (reg_addr == `OFF_PM1)
			hit_pm1 = 1'b1;
		else if (reg_addr == `OFF_PM2)
			hit_pm2 = 1'b1;
		else
			hit_none = 1'b1;
	end

	// Strobe qualified here so each register block sees one enable
	// Unmapped writes fall through and change nothing
	always_comb
	begin
		wr_aic = reg_write && hit_aic;
		wr_cr1 = reg_write && hit_cr1;
		wr_cr2 = reg_write && hit_cr2;
		wr_clk = reg_write && hit_clk;
		wr_rate = reg_write && hit_rate;
		wr_pm1 = reg_write && hit_pm1;
		wr_pm2 = reg_write && hit_pm2;
	end

	// Interface register; bits 7:4 are reserved storage
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			aic_q <= `RST_AIC;
		else if (wr_aic)
			aic_q <= reg_wdata[7:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			cr1_q <= `RST_CR1;
		else if (wr_cr1)
			cr1_q <= reg_wdata[7:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			cr2_q <= `RST_CR2;
		else if (wr_cr2)
			cr2_q <= reg_wdata[7:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			clk_q <= `RST_CLK;
		else if (wr_clk)
			clk_q <= reg_wdata[3:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			rate_q <= `RST_RATE;
		else if (wr_rate)
			rate_q <= reg_wdata[7:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			pm1_q <= `RST_PM1;
		else if (wr_pm1)
			pm1_q <= reg_wdata[7:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			pm2_q <= `RST_PM2;
		else if (wr_pm2)
			pm2_q <= reg_wdata[5:0];
	end

	// Read mux; unmapped addresses and upper bits read zero
	always_comb
	begin
		rdata_d = `RDATA_ZERO;
		if (hit_none)
			rdata_d = `RDATA_ZERO;
		else if (hit_aic)
			rdata_d = {24'h00_0000, aic_q};
		else if (hit_cr1)
			rdata_d = {24'h00_0000, cr1_q};
		else if (hit_cr2)
			rdata_d = {24'h00_0000, cr2_q};
		else if (hit_clk)
			rdata_d = {28'h000_0000, clk_q};
		else if (hit_rate)
			rdata_d = {24'h00_0000, rate_q};
		else if (hit_pm1)
			rdata_d = {24'h00_0000, pm1_q};
		else if (hit_pm2)
			rdata_d = {26'h000_0000, pm2_q};
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			reg_rdata <= `RDATA_ZERO;
		else if (reg_read)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= `RDATA_ZERO;
	end

	// Control outputs are registered copies; one cycle after the write
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			dac_serial <= aic_rst[3];
			adc_serial <= aic_rst[2];
			dac_i2s <= aic_rst[1];
			adc_i2s <= aic_rst[0];
		end
		else
		begin
			dac_serial <= aic_q[3];
			adc_serial <= aic_q[2];
			dac_i2s <= aic_q[1];
			adc_i2s <= aic_q[0];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			mic_bias_powerdown <= cr1_rst[7];
			dac_mono <= cr1_rst[6];
			dac_soft_mute <= cr1_rst[5];
			headphone_disable <= cr1_rst[4];
			mixer_dac_input <= cr1_rst[3];
			mixer_bypass_input <= cr1_rst[2];
			bridge_stage_mute <= cr1_rst[1];
		end
		else
		begin
			mic_bias_powerdown <= cr1_q[7];
			dac_mono <= cr1_q[6];
			dac_soft_mute <= cr1_q[5];
			headphone_disable <= cr1_q[4];
			mixer_dac_input <= cr1_q[3];
			mixer_bypass_input <= cr1_q[2];
			bridge_stage_mute <= cr1_q[1];
		end
	end

	// Unsupported settings are flagged, not corrected: software owns them
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			deemphasis_enable <= cr2_rst[7];
			dac_word_length <= codec_ctrl_pkg::word_length_type'(cr2_rst[6:5]);
			adc_word_length <= codec_ctrl_pkg::word_length_type'(cr2_rst[4:3]);
			word_length_unsupported <= (cr2_rst[6:5] != `WL_16) ||
				(cr2_rst[4:3] != `WL_16);
			adc_highpass_enable <= cr2_rst[2];
			microphone_select <= cr2_rst[1];
		end
		else
		begin
			deemphasis_enable <= cr2_q[7];
			dac_word_length <= codec_ctrl_pkg::word_length_type'(cr2_q[6:5]);
			adc_word_length <= codec_ctrl_pkg::word_length_type'(cr2_q[4:3]);
			word_length_unsupported <= (cr2_q[6:5] != `WL_16) ||
				(cr2_q[4:3] != `WL_16);
			adc_highpass_enable <= cr2_q[2];
			microphone_select <= cr2_q[1];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			master_clock_select <= clk_rst;
			master_clock_unsupported <= (clk_rst != `RST_CLK);
			dac_rate_select <= rate_rst[7:4];
			adc_rate_select <= rate_rst[3:0];
		end
		else
		begin
			master_clock_select <= clk_q;
			master_clock_unsupported <= (clk_q != `RST_CLK);
			dac_rate_select <= rate_q[7:4];
			adc_rate_select <= rate_q[3:0];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			dac_powerdown <= pm1_rst[7];
			output_stage_powerdown <= pm1_rst[6];
			mixer_powerdown <= pm1_rst[5];
			adc_powerdown <= pm1_rst[4];
			line_input_powerdown <= pm1_rst[3];
			bridge_conditioning_powerdown <= pm1_rst[2];
			line_out_powerdown <= pm1_rst[1];
		end
		else
		begin
			dac_powerdown <= pm1_q[7];
			output_stage_powerdown <= pm1_q[6];
			mixer_powerdown <= pm1_q[5];
			adc_powerdown <= pm1_q[4];
			line_input_powerdown <= pm1_q[3];
			bridge_conditioning_powerdown <= pm1_q[2];
			line_out_powerdown <= pm1_q[1];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			mix_gain_couple <=
				codec_ctrl_pkg::gain_couple_type'(pm2_rst[5:4]);
			mic_amp_gain <= pm2_rst[3];
			common_mode_buffer_powerdown <= pm2_rst[2];
			full_powerdown <= pm2_rst[1];
			sleep_select <= pm2_rst[0];
		end
		else
		begin
			// Bit 5 left, bit 4 right; both set means left
			mix_gain_couple <=
				codec_ctrl_pkg::gain_couple_type'(pm2_q[5:4]);
			mic_amp_gain <= pm2_q[3];
			common_mode_buffer_powerdown <= pm2_q[2];
			full_powerdown <= pm2_q[1];
			sleep_select <= pm2_q[0];
		end
	end

endmodule : voice_codec_control_regs

// >>> dv/codec_ctrl_properties.sv
// Port assertions for the codec control bank
`include "codec_ctrl_params.svh"
module codec_ctrl_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	// Fields
	input wire logic dac_serial,
	input wire logic dac_i2s,
	input wire logic dac_soft_mute,
	input wire codec_ctrl_pkg::word_length_type dac_word_length,
	input wire codec_ctrl_pkg::word_length_type adc_word_length,
	input wire logic word_length_unsupported,
	input wire logic [3:0] master_clock_select,
	input wire logic master_clock_unsupported,
	input wire logic [3:0] dac_rate_select,
	input wire codec_ctrl_pkg::gain_couple_type mix_gain_couple
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// Lone write, so the two-edge output lag cannot hide a rewrite
	sequence s_wr(a);
		reg_write && reg_addr == a ##1 !(reg_write && reg_addr == a);
	endsequence
	chk_reset_values: assert property ($rose(rst_b) |->
		dac_serial && dac_soft_mute && !dac_i2s) else $error("reset");
	chk_read_idle: assert property (!$past(reg_read) |->
		reg_rdata == 32'h0) else $error("rdata idle");
	chk_unmapped_zero: assert property (reg_read &&
		(reg_addr > 12'h118 || reg_addr < 12'h100 || reg_addr[1:0] != 2'h0)
		|=> reg_rdata == 32'h0) else $error("unmapped");
	chk_mute_follow: assert property (s_wr(12'h104) |=>
		dac_soft_mute == $past(reg_wdata[5], 2)) else $error("mute");
	chk_rate_follow: assert property (s_wr(12'h110) |=>
		dac_rate_select == $past(reg_wdata[7:4], 2)) else $error("rate");
	chk_couple_follow: assert property (s_wr(12'h118) |=>
		mix_gain_couple == $past(reg_wdata[5:4], 2)) else $error("couple");
	chk_word_flag: assert property (word_length_unsupported ==
		(dac_word_length != 2'h0 || adc_word_length != 2'h0))
		else $error("word");
	chk_clock_flag: assert property (master_clock_unsupported ==
		(master_clock_select != 4'h0)) else $error("clock");
endmodule : codec_ctrl_checker

bind voice_codec_control_regs codec_ctrl_checker chk_u (.sys_clk, .rst_b,
	.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .dac_serial,
	.dac_i2s, .dac_soft_mute, .dac_word_length, .adc_word_length,
	.word_length_unsupported, .master_clock_select, .master_clock_unsupported,
	.dac_rate_select, .mix_gain_couple);

// >>> dv/tb_voice_codec_control_regs.sv
// Self-checking bench for the codec control bank
`include "codec_ctrl_params.svh"
module tb_voice_codec_control_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [`ADDR_W-1:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic dac_serial, adc_serial, dac_i2s, adc_i2s, mic_bias_powerdown;
	logic dac_mono, dac_soft_mute, headphone_disable, mixer_dac_input;
	logic mixer_bypass_input, bridge_stage_mute, deemphasis_enable;
	logic word_length_unsupported, adc_highpass_enable, microphone_select;
	logic [3:0] master_clock_select, dac_rate_select, adc_rate_select;
	logic master_clock_unsupported, dac_powerdown, output_stage_powerdown;
	logic mixer_powerdown, adc_powerdown, line_input_powerdown;
	logic bridge_conditioning_powerdown, line_out_powerdown, mic_amp_gain;
	logic common_mode_buffer_powerdown, full_powerdown, sleep_select;
	codec_ctrl_pkg::word_length_type dac_word_length, adc_word_length;
	codec_ctrl_pkg::gain_couple_type mix_gain_couple;
	// Slot 7 is unmapped, so its mask keeps it at zero
	logic [31:0] shadow [8];
	logic [31:0] field_mask [8] = '{32'hff, 32'hff, 32'hff, 32'hf,
		32'hff, 32'hff, 32'h3f, 32'h0};
	int n_fail = 0;
	int comparisons = 0;
	int seed = 62576;
	int k;
	logic [31:0] rnd_word;
	voice_codec_control_regs dut_u (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .dac_serial, .adc_serial, .dac_i2s,
		.adc_i2s, .mic_bias_powerdown, .dac_mono, .dac_soft_mute,
		.headphone_disable, .mixer_dac_input, .mixer_bypass_input,
		.bridge_stage_mute, .deemphasis_enable, .dac_word_length,
		.adc_word_length, .word_length_unsupported, .adc_highpass_enable,
		.microphone_select, .master_clock_select, .master_clock_unsupported,
		.dac_rate_select, .adc_rate_select, .dac_powerdown,
		.output_stage_powerdown, .mixer_powerdown, .adc_powerdown,
		.line_input_powerdown, .bridge_conditioning_powerdown,
		.line_out_powerdown, .mix_gain_couple, .mic_amp_gain,
		.common_mode_buffer_powerdown, .full_powerdown, .sleep_select);
	always #2 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic wr(input int i, input logic [31:0] d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= 12'h100 + 12'(i * 4);
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		shadow[i] = d & field_mask[i];
	endtask : wr
	task automatic rd(input int i);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= 12'h100 + 12'(i * 4);
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, shadow[i]);
	endtask : rd
	task automatic check_outs;
		#1 chk({dac_serial, adc_serial, dac_i2s, adc_i2s}, shadow[0][3:0]);
		chk({mic_bias_powerdown, dac_mono, dac_soft_mute, headphone_disable,
			mixer_dac_input, mixer_bypass_input, bridge_stage_mute},
			shadow[1][7:1]);
		chk({deemphasis_enable, dac_word_length, adc_word_length,
			adc_highpass_enable, microphone_select}, shadow[2][7:1]);
		chk(word_length_unsupported, shadow[2][6:3] != 4'h0);
		chk({master_clock_unsupported, master_clock_select},
			{shadow[3][3:0] != 4'h0, shadow[3][3:0]});
		chk({dac_rate_select, adc_rate_select}, shadow[4][7:0]);
		chk({dac_powerdown, output_stage_powerdown, mixer_powerdown,
			adc_powerdown, line_input_powerdown, bridge_conditioning_powerdown,
			line_out_powerdown}, shadow[5][7:1]);
		chk({mix_gain_couple, mic_amp_gain, common_mode_buffer_powerdown,
			full_powerdown, sleep_select}, shadow[6][5:0]);
	endtask : check_outs
	task automatic reset_check;
		shadow = '{32'hc, 32'haa, 32'h78, 32'h0, 32'h0, 32'hff, 32'h3, 32'h0};
		check_outs();
		for (int i = 0; i < 8; i++)
			rd(i);
	endtask : reset_check
	task automatic close_out;
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		reset_check();
		// Every code of word length, clock, rates and gain coupling
		for (int v = 0; v < 16; v++)
		begin
			wr(2, 32'(v * 8));
			wr(3, 32'(v));
			wr(4, 32'(v * 15 + 15));
			wr(6, 32'(v * 4));
			repeat (2) @(posedge sys_clk);
			check_outs();
		end
		// Both converter interfaces in I2S mode, serial kept
		wr(0, 32'hf);
		repeat (2) @(posedge sys_clk);
		check_outs();
		repeat (80)
		begin
			k = $unsigned($random(seed)) % 8;
			rnd_word = $random(seed);
			if (k == 0)
				rnd_word[3:2] = 2'b11;
			wr(k, rnd_word);
			rd(k);
			repeat (2) @(posedge sys_clk);
			check_outs();
		end
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		reset_check();
		close_out();
	end
	initial
	begin
		#20000;
		n_fail++;
		close_out();
	end
endmodule : tb_voice_codec_control_regs
